//--- src/deh_evt_if.sv
// Event flag bundle between register file and flag bank
`timescale 1ns/1ps
interface deh_evt_if #(parameter int N = 4);
	logic [N-1:0] set;
	logic [N-1:0] clr;
	logic [N-1:0] flags;
	modport ctrl (output set, output clr, input flags);
	modport bank (input set, input clr, output flags);
endinterface

//--- src/deh_flag_bank.sv
// Sticky event flags, set wins over clear
`timescale 1ns/1ps
module deh_flag_bank #(
	parameter int N = 4
) (
	input wire logic clk, // clock
	input wire logic rst, // async reset
	deh_evt_if.bank ev // set, clear and flag state
);
	logic [N-1:0] flag_q;
	logic [N-1:0] flag_d;
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_flag
			always_comb begin
				flag_d[i] = ev.set[i] | (flag_q[i] & ~ev.clr[i]);
			end
		end
	endgenerate
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_q <= '0;
		end else begin
			flag_q <= flag_d;
		end
	end
	assign ev.flags = flag_q;
endmodule

//--- src/deh_host_ctrl.sv
// Host control and status registers of the 2D drawing engine
//
// Summary of operation
// - Status bits 0-3 report four engine events
// - Status bit 7 shows 4 or 8 bit planes while config extension field is 00, else reads 0
// - Shared address reads status, writes control
// - Writing one clears matching status bit
// - Bits 8-11 enable interrupts under global enable
// - Bits 15-14: keep, enable, hold reset, reserved
// - Function bit 0 selects advanced modes
// - Function bit 2 selects advanced pixel depth
// - Linear enable is OR of two bits
// - Current Y write sets, read returns engine
// - Current X write sets, read returns engine
// - Drawing registers accessible only with config bit 0
`timescale 1ns/1ps
`include "deh_regs.svh"
module deh_host_ctrl #(
	parameter int CW = `DEH_COORD_W
) (
	input wire logic clk, // clock, 20 MHz
	input wire logic rst, // async reset, active high
	input wire logic [15:0] addr, // register byte address
	input wire logic [15:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [15:0] rdata, // read data, one cycle after rd
	input wire logic ev_vsync, // vertical sync event pulse
	input wire logic ev_busy, // engine busy event pulse
	input wire logic ev_overflow, // command queue overflow pulse
	input wire logic ev_empty, // command queue empty pulse
	input wire logic eng_pos_we, // engine updates its position
	input wire logic [CW-1:0] eng_x, // engine present X
	input wire logic [CW-1:0] eng_y, // engine present Y
	input wire logic eight_bit_planes, // 8-bit plane organisation
	output logic irq, // level interrupt
	output logic engine_soft_reset, // engine held in reset
	output logic engine_enable, // engine enabled
	output logic advanced_modes_select, // advanced/non-planar modes
	output logic advanced_pixel_depth, // 8 or more bits per pixel
	output logic linear_addressing_enable, // effective linear enable
	output logic [CW-1:0] start_x, // programmed start X
	output logic [CW-1:0] start_y, // programmed start Y
	output logic start_x_load, // pulse on start X write
	output logic start_y_load // pulse on start Y write
);
	localparam int N = `DEH_EV_N;
	deh_evt_if #(.N(N)) ev ();
	deh_flag_bank #(.N(N)) u_flags (
		.clk(clk),
		.rst(rst),
		.ev(ev)
	);

	logic [N-1:0] en_q, en_d;
	deh_pkg::deh_eng_cmd_e eng_q, eng_d;
	logic [15:0] func_q, func_d;
	logic [15:0] cfg_q, cfg_d;
	logic [CW-1:0] cx_q, cx_d, cy_q, cy_d;
	logic [15:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	logic lx_q, lx_d, ly_q, ly_d;
	logic srst_q, srst_d, eena_q, eena_d;
	logic adv_q, adv_d, dep_q, dep_d, lin_q, lin_d;
	logic wr_sc, wr_fc, wr_cy, wr_cx, wr_mask, wr_cfg;
	logic access_ok;
	logic hit_sc, hit_fc, hit_cy, hit_cx, hit_mask, hit_cfg;
	logic [15:0] status_w;
	logic gie;

	// Drawing registers vanish from the map unless config allows them
	assign access_ok = cfg_q[`DEH_CFG_ACCESS_BIT];
	assign gie = cfg_q[`DEH_CFG_GIE_BIT];

	always_comb begin
		hit_sc = 1'b0;
		hit_fc = 1'b0;
		hit_cy = 1'b0;
		hit_cx = 1'b0;
		hit_mask = 1'b0;
		hit_cfg = 1'b0;
		if (addr == `DEH_OFS_SYS_CFG) begin
			hit_cfg = 1'b1;
		end else if (addr == `DEH_OFS_IRQ_MASK) begin
			hit_mask = 1'b1;
		end else if (access_ok && addr == `DEH_OFS_STAT_CTRL) begin
			hit_sc = 1'b1;
		end else if (access_ok && addr == `DEH_OFS_FUNC_CTRL) begin
			hit_fc = 1'b1;
		end else if (access_ok && addr == `DEH_OFS_CUR_Y) begin
			hit_cy = 1'b1;
		end else if (access_ok && addr == `DEH_OFS_CUR_X) begin
			hit_cx = 1'b1;
		end
	end

	always_comb begin
		status_w = 16'h0000;
		status_w[N-1:0] = ev.flags;
		// Plane count only meaningful while the extension field is 00b
		status_w[`DEH_STAT_PLANE_BIT] = eight_bit_planes
			& (cfg_q[`DEH_CFG_EXT_LSB+1:`DEH_CFG_EXT_LSB] == 2'b00);
	end

	// Write strobes qualified by the decoded register
	always_comb begin
		wr_sc = wr & hit_sc;
		wr_fc = wr & hit_fc;
		wr_cy = wr & hit_cy;
		wr_cx = wr & hit_cx;
		wr_mask = wr & hit_mask;
		wr_cfg = wr & hit_cfg;
	end

	// An event in the same cycle as its clear wins in the flag bank
	always_comb begin
		ev.set = {ev_empty, ev_overflow, ev_busy, ev_vsync};
		ev.clr = '0;
		if (wr_sc) begin
			ev.clr = wdata[N-1:0];
		end
	end

	// Enables live in the control word and are mirrored at the mask address
	always_comb begin
		en_d = en_q;
		if (wr_sc) begin
			en_d = wdata[`DEH_EN_LSB+N-1:`DEH_EN_LSB];
		end else if (wr_mask) begin
			en_d = wdata[N-1:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			en_q <= '0;
		end else begin
			en_q <= en_d;
		end
	end

	// Field 00 keeps the engine as is; reserved 11 is treated the same
	always_comb begin
		eng_d = eng_q;
		if (wr_sc) begin
			case (wdata[`DEH_RST_LSB+1:`DEH_RST_LSB])
				2'b01: eng_d = deh_pkg::DEH_ENG_RUN;
				2'b10: eng_d = deh_pkg::DEH_ENG_RESET;
				default: eng_d = eng_q;
			endcase
		end
		srst_d = (eng_d == deh_pkg::DEH_ENG_RESET);
		eena_d = (eng_d == deh_pkg::DEH_ENG_RUN);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			eng_q <= deh_pkg::DEH_ENG_KEEP;
			srst_q <= 1'b0;
			eena_q <= 1'b0;
		end else begin
			eng_q <= eng_d;
			srst_q <= srst_d;
			eena_q <= eena_d;
		end
	end

	// Reserved function bits are held at zero whatever is written
	always_comb begin
		func_d = func_q;
		if (wr_fc) begin
			func_d = wdata & `DEH_FC_MASK;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			func_q <= `DEH_CTRL_RESET;
		end else begin
			func_q <= func_d;
		end
	end

	// Config stays decoded so software can always reopen the map
	always_comb begin
		cfg_d = cfg_q;
		if (wr_cfg) begin
			cfg_d = wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q <= `DEH_CFG_RESET;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// Mode pins follow the next register values so they change with them
	always_comb begin
		adv_d = func_d[`DEH_FC_ADV_BIT];
		dep_d = func_d[`DEH_FC_DEPTH_BIT];
		lin_d = func_d[`DEH_FC_LIN_BIT] | cfg_d[`DEH_CFG_MEMLIN_BIT];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			adv_q <= 1'b0;
			dep_q <= 1'b0;
			lin_q <= 1'b0;
		end else begin
			adv_q <= adv_d;
			dep_q <= dep_d;
			lin_q <= lin_d;
		end
	end

	// A host write wins over an engine update in the same cycle
	always_comb begin
		cx_d = cx_q;
		cy_d = cy_q;
		lx_d = 1'b0;
		ly_d = 1'b0;
		if (eng_pos_we) begin
			cx_d = eng_x;
			cy_d = eng_y;
		end
		if (wr_cy) begin
			cy_d = wdata[CW-1:0];
			ly_d = 1'b1;
		end
		if (wr_cx) begin
			cx_d = wdata[CW-1:0];
			lx_d = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cx_q <= '0;
			cy_q <= '0;
			lx_q <= 1'b0;
			ly_q <= 1'b0;
		end else begin
			cx_q <= cx_d;
			cy_q <= cy_d;
			lx_q <= lx_d;
			ly_q <= ly_d;
		end
	end

	always_comb begin
		rdata_d = 16'h0000;
		if (rd) begin
			if (hit_sc) begin
				rdata_d = status_w;
			end else if (hit_fc) begin
				rdata_d = func_q;
			end else if (hit_cy) begin
				rdata_d = {{(16-CW){1'b0}}, cy_q};
			end else if (hit_cx) begin
				rdata_d = {{(16-CW){1'b0}}, cx_q};
			end else if (hit_mask) begin
				rdata_d = {{(16-N){1'b0}}, en_q};
			end else if (hit_cfg) begin
				rdata_d = cfg_q;
			end
		end
	end

	// Read data stands for the one cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Global enable gates every source
	always_comb begin
		irq_d = gie & |(ev.flags & en_q);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign rdata = rdata_q;
	assign irq = irq_q;
	assign engine_soft_reset = srst_q;
	assign engine_enable = eena_q;
	assign advanced_modes_select = adv_q;
	assign advanced_pixel_depth = dep_q;
	assign linear_addressing_enable = lin_q;
	assign start_x = cx_q;
	assign start_y = cy_q;
	assign start_x_load = lx_q;
	assign start_y_load = ly_q;
endmodule

//--- src/deh_pkg.sv
// Types shared by the drawing host control block
package deh_pkg;
	typedef enum logic [1:0] {
		DEH_ENG_KEEP,
		DEH_ENG_RUN,
		DEH_ENG_RESET,
		DEH_ENG_RSVD
	} deh_eng_cmd_e;
	typedef logic [15:0] deh_word_t;
endpackage

//--- src/deh_regs.svh
// Register offsets, field positions, reset values and widths for the drawing host control block
`ifndef DEH_REGS_SVH
`define DEH_REGS_SVH
`define DEH_ADDR_W 16
`define DEH_OFS_STAT_CTRL 16'h42E8
`define DEH_OFS_FUNC_CTRL 16'h4AE8
`define DEH_OFS_CUR_Y 16'h82E8
`define DEH_OFS_CUR_X 16'h86E8
`define DEH_OFS_IRQ_MASK 16'hF000
`define DEH_OFS_SYS_CFG 16'hF004
`define DEH_EV_N 4
`define DEH_STAT_PLANE_BIT 7
`define DEH_EN_LSB 8
`define DEH_RST_LSB 14
`define DEH_FC_ADV_BIT 0
`define DEH_FC_DEPTH_BIT 2
`define DEH_FC_LIN_BIT 4
`define DEH_FC_MASK 16'h0015
`define DEH_CFG_ACCESS_BIT 0
`define DEH_CFG_GIE_BIT 1
`define DEH_CFG_MEMLIN_BIT 2
`define DEH_CFG_EXT_LSB 4
`define DEH_CFG_RESET 16'h0000
`define DEH_CTRL_RESET 16'h0000
`define DEH_COORD_W 12
`endif

//--- verif/deh_host_ctrl_properties.sv
// Port checker for the drawing host control block
`timescale 1ns/1ps
`include "deh_regs.svh"
module deh_host_ctrl_chk #(
	parameter int CW = 12
) (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic [15:0] addr, // address
	input wire logic [15:0] wdata, // data in
	input wire logic wr, // write
	input wire logic rd, // read
	input wire logic [15:0] rdata, // data out
	input wire logic irq, // interrupt
	input wire logic engine_soft_reset, // held
	input wire logic engine_enable, // running
	input wire logic advanced_modes_select, // mode
	input wire logic advanced_pixel_depth, // depth
	input wire logic linear_addressing_enable, // linear
	input wire logic [CW-1:0] start_x, // start X
	input wire logic start_x_load // X load
);
	logic [15:0] cfg_q;
	logic [15:0] cfg_d;
	// Shadow of the config word, since access and global enable gate the rest
	always_comb cfg_d = (wr && addr == `DEH_OFS_SYS_CFG) ? wdata : cfg_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cfg_q <= 16'h0000;
		else
			cfg_q <= cfg_d;
	end
	wire sc = wr && addr == `DEH_OFS_STAT_CTRL;
	wire sca = sc && cfg_q[0];
	wire fc = wr && cfg_q[0] && addr == `DEH_OFS_FUNC_CTRL;
	wire xw = wr && cfg_q[0] && addr == `DEH_OFS_CUR_X;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_rd_idle;
		!$past(rd) |-> rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata idle");
	property p_run;
		sca && wdata[15:14] == 2'h1 |=> engine_enable && !engine_soft_reset;
	endproperty
	a_run: assert property (p_run) else $error("engine run");
	property p_hold;
		sca && wdata[15:14] == 2'h2 |=> engine_soft_reset && !engine_enable;
	endproperty
	a_hold: assert property (p_hold) else $error("engine hold");
	property p_keep;
		sc && wdata[15] == wdata[14] |=> $stable(engine_enable) && $stable(engine_soft_reset);
	endproperty
	a_keep: assert property (p_keep) else $error("engine keep");
	property p_func;
		fc |=> advanced_modes_select == $past(wdata[0]) && advanced_pixel_depth == $past(wdata[2]);
	endproperty
	a_func: assert property (p_func) else $error("func bits");
	property p_lin;
		fc |=> linear_addressing_enable == ($past(wdata[4]) || cfg_q[2]);
	endproperty
	a_lin: assert property (p_lin) else $error("linear");
	property p_x;
		xw |=> start_x_load && start_x == $past(wdata[CW-1:0]);
	endproperty
	a_x: assert property (p_x) else $error("start x");
	property p_gie;
		!cfg_q[1] |=> !irq;
	endproperty
	a_gie: assert property (p_gie) else $error("irq gie");
	c_hold: cover property (p_hold);
	c_irq: cover property ($rose(irq));
	c_x: cover property (start_x_load);
endmodule
bind deh_host_ctrl deh_host_ctrl_chk #(.CW(CW)) deh_host_ctrl_chk_inst (
	.clk(clk),
	.rst(rst),
	.addr(addr),
	.wdata(wdata),
	.wr(wr),
	.rd(rd),
	.rdata(rdata),
	.irq(irq),
	.engine_soft_reset(engine_soft_reset),
	.engine_enable(engine_enable),
	.advanced_modes_select(advanced_modes_select),
	.advanced_pixel_depth(advanced_pixel_depth),
	.linear_addressing_enable(linear_addressing_enable),
	.start_x(start_x),
	.start_x_load(start_x_load)
);

//--- verif/tb_top.sv
// Testbench for the drawing host control block
`timescale 1ns/1ps
`include "deh_regs.svh"
module tb_top;
	localparam ST = `DEH_OFS_STAT_CTRL;
	localparam FC = `DEH_OFS_FUNC_CTRL;
	localparam CY = `DEH_OFS_CUR_Y;
	localparam CX = `DEH_OFS_CUR_X;
	localparam SC = `DEH_OFS_SYS_CFG;
	localparam MK = `DEH_OFS_IRQ_MASK;
	logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, eng_pos_we = 1'h0;
	logic eight_bit_planes = 1'h0, ev_vsync = 1'h0, ev_busy = 1'h0;
	logic ev_overflow = 1'h0, ev_empty = 1'h0;
	logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
	logic [11:0] eng_x = 12'h000, eng_y = 12'h000, start_x, start_y;
	logic irq, engine_soft_reset, engine_enable, advanced_modes_select;
	logic advanced_pixel_depth, linear_addressing_enable, start_x_load, start_y_load;
	wire [15:0] iq = {15'h0000, irq};
	wire [15:0] fo = {11'h000, linear_addressing_enable, 1'h0, advanced_pixel_depth, 1'h0,
		advanced_modes_select};
	int n_fail = 0;
	int n_compared = 0;
	always #25 clk = ~clk;
	deh_host_ctrl deh_host_ctrl_inst (
		.clk(clk),
		.rst(rst),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.ev_vsync(ev_vsync),
		.ev_busy(ev_busy),
		.ev_overflow(ev_overflow),
		.ev_empty(ev_empty),
		.eng_pos_we(eng_pos_we),
		.eng_x(eng_x),
		.eng_y(eng_y),
		.eight_bit_planes(eight_bit_planes),
		.irq(irq),
		.engine_soft_reset(engine_soft_reset),
		.engine_enable(engine_enable),
		.advanced_modes_select(advanced_modes_select),
		.advanced_pixel_depth(advanced_pixel_depth),
		.linear_addressing_enable(linear_addressing_enable),
		.start_x(start_x),
		.start_y(start_y),
		.start_x_load(start_x_load),
		.start_y_load(start_y_load)
	);
	task ck(input logic [15:0] s, input logic [15:0] e, input string n);
		n_compared++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			n_fail++;
		end
	endtask
	task wreg(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
		#1;
	endtask
	task rreg(input logic [15:0] a, input logic [15:0] e, input string n);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		ck(rdata, e, n);
	endtask
	task t_rst;
		ck(rdata, 16'h0000, "rdata at reset");
		ck(iq, 16'h0000, "irq at reset");
		ck(fo, 16'h0000, "func at reset");
		ck({14'h0000, engine_enable, engine_soft_reset}, 16'h0000, "eng at reset");
		ck({14'h0000, start_x_load, start_y_load}, 16'h0000, "loads at reset");
		ck({4'h0, start_x}, 16'h0000, "x at reset");
		ck({4'h0, start_y}, 16'h0000, "y at reset");
	endtask
	task t_gate;
		wreg(FC, 16'h0015);
		rreg(FC, 16'h0000, "gated");
		wreg(SC, 16'h0003);
		rreg(FC, 16'h0000, "gated write");
		rreg(ST, 16'h0000, "status");
		rreg(16'h1234, 16'h0000, "unmapped");
		wreg(MK, 16'h000A);
		rreg(MK, 16'h000A, "mask");
		wreg(ST, 16'h0000);
		rreg(MK, 16'h0000, "mask");
	endtask
	task t_func;
		wreg(FC, 16'h0015);
		ck(fo, 16'h0015, "func");
		rreg(FC, 16'h0015, "func read");
		wreg(FC, 16'h0000);
		ck(fo, 16'h0000, "func");
		wreg(SC, 16'h0007);
		@(posedge clk);
		#1;
		ck(fo, 16'h0010, "linear");
		wreg(SC, 16'h0003);
	endtask
	task t_ev;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			{ev_empty, ev_overflow, ev_busy, ev_vsync} <= 4'h1 << i;
			@(posedge clk);
			{ev_empty, ev_overflow, ev_busy, ev_vsync} <= 4'h0;
			rreg(ST, 16'h0001 << i, "flag");
			ck(iq, 16'h0000, "masked");
			wreg(ST, 16'h0100 << i);
			rreg(ST, 16'h0001 << i, "kept");
			ck(iq, 16'h0001, "irq");
			wreg(SC, 16'h0001);
			@(posedge clk);
			#1;
			ck(iq, 16'h0000, "gie");
			wreg(SC, 16'h0003);
			wreg(ST, 16'h0101 << i);
			rreg(ST, 16'h0000, "clear");
			ck(iq, 16'h0000, "irq");
		end
		@(posedge clk);
		ev_vsync <= 1'h1;
		addr <= ST;
		wdata <= 16'h0001;
		wr <= 1'h1;
		@(posedge clk);
		ev_vsync <= 1'h0;
		wr <= 1'h0;
		rreg(ST, 16'h0001, "set wins");
		wreg(ST, 16'h0001);
		rreg(ST, 16'h0000, "clear");
		@(posedge clk);
		eight_bit_planes <= 1'h1;
		rreg(ST, 16'h0080, "planes");
		wreg(SC, 16'h0013);
		rreg(ST, 16'h0000, "planes ext");
		wreg(SC, 16'h0003);
		rreg(ST, 16'h0080, "planes");
	endtask
	task automatic t_eng;
		logic [1:0] c [5] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h1};
		logic [1:0] e [5] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h2};
		for (int k = 0; k < 5; k++) begin
			wreg(ST, {c[k], 14'h0000});
			ck({14'h0000, engine_enable, engine_soft_reset}, {14'h0000, e[k]}, "eng");
		end
	endtask
	task t_xy;
		wreg(CX, 16'h0ABC);
		ck({3'h0, start_x_load, start_x}, 16'h1ABC, "x");
		wreg(CY, 16'h0DEF);
		ck({3'h0, start_y_load, start_y}, 16'h1DEF, "y");
		rreg(CX, 16'h0ABC, "x");
		@(posedge clk);
		eng_x <= 12'h123;
		eng_y <= 12'h456;
		eng_pos_we <= 1'h1;
		@(posedge clk);
		eng_pos_we <= 1'h0;
		rreg(CX, 16'h0123, "x");
		rreg(CY, 16'h0456, "y");
	endtask
	task print_verdict;
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		#1;
		t_rst;
		t_gate;
		t_func;
		t_ev;
		t_eng;
		t_xy;
		print_verdict;
	end
endmodule
